// ===== core/psf_map.svh
`ifndef PSF_MAP_SVH
`define PSF_MAP_SVH

// ****************************************
// Register indices and bus widths
// ****************************************
`define PSF_IDX_IPLO      6'h06
`define PSF_IDX_BANK      6'h10
`define PSF_IDX_STAT      6'h11
`define PSF_ADDR_W        8
`define PSF_DATA_W        32

// ****************************************
// Field layout and reset values
// ****************************************
`define PSF_PC_W          13
`define PSF_BANK_W        4
`define PSF_FETCH_W       17
`define PSF_INSTR_W       16
`define PSF_PAGE_LSB      8
`define PSF_PC_RESET      13'h0000
`define PSF_BANK_RESET    4'h0
`define PSF_VEC_T0        13'h0008
`define PSF_VEC_T1        13'h000C
`define PSF_STAT_PEND_BIT 20

// ****************************************
// Timing counts
// ****************************************
`define PSF_OSC_DIV       2
`define PSF_PHASES        4
`define PSF_LAST_PHASE    2'h3
`define PSF_BANK_DELAY    2'h2
`endif

// ===== core/psf_pkg.sv
package psf_pkg;
  // Control transfer requested by the execute stage
  typedef enum logic [2:0] {
    PSF_OP_NONE  = 3'b000,
    PSF_OP_JUMP  = 3'b001,
    PSF_OP_CALL  = 3'b010,
    PSF_OP_RET   = 3'b011,
    PSF_OP_SKIP  = 3'b100,
    PSF_OP_IPLO  = 3'b101
  } psf_op_t;

  // Contents of the execute slot
  typedef enum logic [1:0] {
    PSF_SLOT_EMPTY = 2'b00,
    PSF_SLOT_EXEC  = 2'b01,
    PSF_SLOT_DUMMY = 2'b10
  } psf_slot_t;
endpackage

// ===== core/psf_if.sv
`timescale 1ns/1ps
interface psf_if;
  logic       cyc_last;
  logic [1:0] phase;
  logic       iplo_wr;
  logic [7:0] iplo_wdata;
  logic       bank_wr;
  logic [3:0] bank_wdata;
  logic [12:0] pc_view;
  logic [3:0] bank_view;
  logic       iplo_pend_view;
  logic [1:0] bank_stage_view;

  modport phase_gen (output cyc_last, output phase);
  modport bus (output iplo_wr, output iplo_wdata, output bank_wr, output bank_wdata,
               input pc_view, input bank_view, input iplo_pend_view, input bank_stage_view);
  modport core (input cyc_last, input phase, input iplo_wr, input iplo_wdata,
                input bank_wr, input bank_wdata, output pc_view, output bank_view,
                output iplo_pend_view, output bank_stage_view);
endinterface

// ===== core/psf_phase.sv
`timescale 1ns/1ps
`include "psf_map.svh"
module psf_phase
  import psf_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  psf_if.phase_gen  ph
);
  logic       div_r;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic       last_r;

  // Phase advances on every second oscillator edge
  always_comb begin
    phase_nxt = phase_r;
    if (div_r) begin
      phase_nxt = phase_r + 2'h1;
    end
  end

  // Divide by two: div_r high marks the system clock tick
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end

  // Four phases per instruction cycle, wrap is natural in two bits
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      phase_r <= 2'h0;
      last_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      last_r  <= ~div_r & (phase_nxt == `PSF_LAST_PHASE);
    end
  end

  assign ph.cyc_last = last_r;
  assign ph.phase    = phase_r;
endmodule

// ===== core/psf_avmm.sv
`timescale 1ns/1ps
`include "psf_map.svh"
module psf_avmm
  import psf_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  psf_if.bus               rb
);
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        iplo_wr_r;
  logic [7:0]  iplo_wdata_r;
  logic        bank_wr_r;
  logic [3:0]  bank_wdata_r;
  logic        take_wr;

  // Byte address of a word register from its index
  function automatic logic [7:0] psf_byte_addr(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  // Every access is held one cycle, then released with waitrequest low
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
    end
  end

  // Read data is ready in the cycle waitrequest falls; unmapped reads zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_r <= 32'h00000000;
    end else if (avs_read_i & wait_r) begin
      rdata_r <= 32'h00000000;
      if (avs_address_i == psf_byte_addr(`PSF_IDX_IPLO)) begin
        rdata_r[7:0] <= rb.pc_view[7:0];
      end else if (avs_address_i == psf_byte_addr(`PSF_IDX_BANK)) begin
        rdata_r[3:0] <= rb.bank_view;
      end else if (avs_address_i == psf_byte_addr(`PSF_IDX_STAT)) begin
        rdata_r[16:0] <= {rb.bank_view, rb.pc_view};
        rdata_r[`PSF_STAT_PEND_BIT] <= rb.iplo_pend_view;
        rdata_r[22:21] <= rb.bank_stage_view;
      end
    end
  end

  assign take_wr = avs_write_i & ~wait_r & avs_byteenable_i[0];

  // Write strobes last one cycle; writes elsewhere are dropped silently
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      iplo_wr_r    <= 1'b0;
      iplo_wdata_r <= 8'h00;
      bank_wr_r    <= 1'b0;
      bank_wdata_r <= 4'h0;
    end else begin
      iplo_wr_r <= take_wr & (avs_address_i == psf_byte_addr(`PSF_IDX_IPLO));
      bank_wr_r <= take_wr & (avs_address_i == psf_byte_addr(`PSF_IDX_BANK));
      if (take_wr) begin
        iplo_wdata_r <= avs_writedata_i[7:0];
        bank_wdata_r <= avs_writedata_i[3:0];
      end
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;
  assign rb.iplo_wr        = iplo_wr_r;
  assign rb.iplo_wdata     = iplo_wdata_r;
  assign rb.bank_wr        = bank_wr_r;
  assign rb.bank_wdata     = bank_wdata_r;
endmodule

// ===== core/psf_sequencer.sv
`timescale 1ns/1ps
`include "psf_map.svh"
module psf_sequencer
  import psf_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // Register bus
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Program ROM
  output logic      [16:0] rom_addr_o,
  output logic             rom_rd_o,
  input  wire logic [15:0] rom_data_i,
  // Decoder and execute stage
  output logic      [15:0] instr_o,
  output logic             instr_valid_o,
  output logic      [12:0] instr_addr_o,
  output logic             dummy_o,
  output logic             cycle_last_o,
  output logic      [1:0]  phase_o,
  input  wire logic [2:0]  ctl_op_i,
  input  wire logic [12:0] ctl_target_i,
  input  wire logic        skip_true_i,
  input  wire logic        irq_t0_i,
  input  wire logic        irq_t1_i,
  output logic             irq_ack_o,
  output logic             push_o,
  output logic      [12:0] link_addr_o
);

  // ****************************************
  // Shared wiring
  // ****************************************
  psf_if sq_if ();

  psf_phase u_phase (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .ph        (sq_if.phase_gen)
  );

  psf_avmm u_avmm (
    .ref_clk_i         (ref_clk_i),
    .srst_i            (srst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .rb                (sq_if.bus)
  );

  // ****************************************
  // State
  // ****************************************
  logic [12:0] pc_r;
  logic [12:0] pc_inc;
  logic [12:0] pc_nxt;
  logic [3:0]  bank_r;
  logic [3:0]  bank_nxt;
  logic [3:0]  bank_pend_r;
  logic [1:0]  bank_stage_r;
  logic        iplo_pend_r;
  logic [7:0]  iplo_data_r;
  psf_slot_t   slot_r;
  psf_op_t     op;
  logic        cyc_end;
  logic        slot_exec;
  logic        xfer;
  logic        xfer_push;
  logic        xfer_irq;
  logic        bus_jump;
  logic [12:0] xfer_tgt;
  logic [16:0] rom_addr_r;
  logic        rom_rd_r;
  logic [15:0] instr_r;
  logic        instr_valid_r;
  logic [12:0] instr_addr_r;
  logic        dummy_r;
  logic        last_r;
  logic [1:0]  phase_r;
  logic        irq_ack_r;
  logic        push_r;
  logic [12:0] link_r;

  // Replace the low byte, keeping the page of the word being fetched
  function automatic logic [12:0] psf_page_jump(input logic [12:0] pc,
                                                input logic [7:0] lo);
    return {pc[12:`PSF_PAGE_LSB], lo};
  endfunction

  assign op        = psf_op_t'(ctl_op_i);
  assign cyc_end   = sq_if.cyc_last;
  assign slot_exec = (slot_r == PSF_SLOT_EXEC);
  // Increment wraps inside the 13-bit space; the bank is a separate register
  assign pc_inc    = pc_r + 13'h0001;

  // ****************************************
  // Control transfer selection
  // ****************************************
  // Execute-stage transfers win over interrupts; a bus low byte write waits
  // behind both and behind a dummy slot, so it never tears a counter change.
  always_comb begin
    xfer      = 1'b0;
    xfer_push = 1'b0;
    xfer_irq  = 1'b0;
    bus_jump  = 1'b0;
    xfer_tgt  = pc_inc;
    if (slot_exec) begin
      case (op)
        PSF_OP_JUMP: begin
          xfer     = 1'b1;
          xfer_tgt = ctl_target_i;
        end
        PSF_OP_CALL: begin
          xfer      = 1'b1;
          xfer_push = 1'b1;
          xfer_tgt  = ctl_target_i;
        end
        PSF_OP_RET: begin
          xfer     = 1'b1;
          xfer_tgt = ctl_target_i;
        end
        PSF_OP_SKIP: begin
          // The word under fetch is the one skipped; resume after it
          if (skip_true_i) begin
            xfer     = 1'b1;
            xfer_tgt = pc_inc;
          end
        end
        PSF_OP_IPLO: begin
          xfer     = 1'b1;
          xfer_tgt = psf_page_jump(pc_r, ctl_target_i[7:0]);
        end
        default: begin
          xfer = 1'b0;
        end
      endcase
      if (!xfer && (irq_t0_i || irq_t1_i)) begin
        xfer      = 1'b1;
        xfer_push = 1'b1;
        xfer_irq  = 1'b1;
        xfer_tgt  = irq_t0_i ? `PSF_VEC_T0 : `PSF_VEC_T1;
      end
    end
    if (!xfer && iplo_pend_r && (slot_r != PSF_SLOT_DUMMY)) begin
      xfer     = 1'b1;
      bus_jump = 1'b1;
      xfer_tgt = psf_page_jump(pc_r, iplo_data_r);
    end
  end

  assign pc_nxt = xfer ? xfer_tgt : pc_inc;

  // Bank becomes live at the second cycle end after the write
  always_comb begin
    bank_nxt = bank_r;
    if (bank_stage_r == `PSF_BANK_DELAY) begin
      bank_nxt = bank_pend_r;
    end
  end

  // ****************************************
  // Program counter and fetch address
  // ****************************************
  // Reset forces word 000H of bank zero; the outside drives reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pc_r       <= `PSF_PC_RESET;
      rom_addr_r <= {`PSF_BANK_RESET, `PSF_PC_RESET};
      rom_rd_r   <= 1'b0;
    end else begin
      rom_rd_r <= 1'b1;
      if (cyc_end) begin
        pc_r       <= pc_nxt;
        rom_addr_r <= {bank_nxt, pc_nxt};
      end
    end
  end

  // ****************************************
  // Bank selector with delayed effect
  // ****************************************
  // A new write restarts the delay, so the latest value is the one applied
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bank_r       <= `PSF_BANK_RESET;
      bank_pend_r  <= `PSF_BANK_RESET;
      bank_stage_r <= 2'h0;
    end else begin
      if (cyc_end) begin
        bank_r <= bank_nxt;
      end
      if (sq_if.bank_wr) begin
        bank_pend_r  <= sq_if.bank_wdata;
        bank_stage_r <= 2'h1;
      end else if (cyc_end && bank_stage_r != 2'h0) begin
        bank_stage_r <= (bank_stage_r == `PSF_BANK_DELAY) ? 2'h0 : bank_stage_r + 2'h1;
      end
    end
  end

  // ****************************************
  // Pending bus write of the low byte
  // ****************************************
  // A write landing on the consuming edge is kept: the set wins
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      iplo_pend_r <= 1'b0;
      iplo_data_r <= 8'h00;
    end else begin
      if (sq_if.iplo_wr) begin
        iplo_pend_r <= 1'b1;
        iplo_data_r <= sq_if.iplo_wdata;
      end else if (cyc_end && bus_jump) begin
        iplo_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Fetch to execute pipeline
  // ****************************************
  // The word fetched this cycle moves to execute; after a transfer it is
  // marked as dummy so the decoder keeps all state unchanged.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      slot_r        <= PSF_SLOT_EMPTY;
      instr_r       <= 16'h0000;
      instr_valid_r <= 1'b0;
      instr_addr_r  <= `PSF_PC_RESET;
      dummy_r       <= 1'b0;
    end else if (cyc_end) begin
      instr_r       <= rom_data_i;
      instr_addr_r  <= pc_r;
      slot_r        <= xfer ? PSF_SLOT_DUMMY : PSF_SLOT_EXEC;
      instr_valid_r <= ~xfer;
      dummy_r       <= xfer;
    end
  end

  // ****************************************
  // Stack handshake toward execute
  // ****************************************
  // Return address is the word that was under fetch and got discarded
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_ack_r <= 1'b0;
      push_r    <= 1'b0;
      link_r    <= `PSF_PC_RESET;
    end else begin
      irq_ack_r <= cyc_end & xfer_irq;
      push_r    <= cyc_end & xfer_push;
      if (cyc_end && xfer_push) begin
        link_r <= pc_r;
      end
    end
  end

  // ****************************************
  // Phase outputs
  // ****************************************
  // Copies keep the top outputs on flops; they lag the internal ones by one
  // edge, which matters only to a decoder that reads them combinationally.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      last_r  <= 1'b0;
      phase_r <= 2'h0;
    end else begin
      last_r  <= sq_if.cyc_last;
      phase_r <= sq_if.phase;
    end
  end

  // Views for the register file
  assign sq_if.pc_view         = pc_r;
  assign sq_if.bank_view       = bank_r;
  assign sq_if.iplo_pend_view  = iplo_pend_r;
  assign sq_if.bank_stage_view = bank_stage_r;

  assign rom_addr_o    = rom_addr_r;
  assign rom_rd_o      = rom_rd_r;
  assign instr_o       = instr_r;
  assign instr_valid_o = instr_valid_r;
  assign instr_addr_o  = instr_addr_r;
  assign dummy_o       = dummy_r;
  assign cycle_last_o  = last_r;
  assign phase_o       = phase_r;
  assign irq_ack_o     = irq_ack_r;
  assign push_o        = push_r;
  assign link_addr_o   = link_r;
endmodule

// ===== bench/psf_sequencer_sva.sv
`timescale 1ns/1ps
module psf_sva
  import psf_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        srst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [16:0] rom_addr_o,
  input wire logic [12:0] instr_addr_o,
  input wire logic        instr_valid_o,
  input wire logic        dummy_o,
  input wire logic        cycle_last_o,
  input wire logic [1:0]  phase_o,
  input wire logic [2:0]  ctl_op_i,
  input wire logic [12:0] ctl_target_i,
  input wire logic        skip_true_i,
  input wire logic        irq_t0_i,
  input wire logic        irq_t1_i
);
  // ********
  // Sequencer checks
  // ********
  // Checks other than fetch_hold_a, reset_a and bus_ans_a are judged at the sample where a new slot has just begun
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  cyc_period_a: assert property (cycle_last_o |=> !cycle_last_o [*7] ##1 cycle_last_o)
    else $error("instruction cycle is not eight clocks");
  fetch_hold_a: assert property ($changed(rom_addr_o) |-> cycle_last_o)
    else $error("fetch address moved inside a cycle");
  instr_tag_a: assert property (cycle_last_o |-> instr_addr_o == $past(rom_addr_o[12:0]))
    else $error("executed word is not the word fetched before");
  seq_incr_a: assert property (cycle_last_o && !dummy_o |->
    rom_addr_o[12:0] == instr_addr_o + 13'h0001)
    else $error("counter did not advance by one");
  xfer_dummy_a: assert property (cycle_last_o && $past(instr_valid_o) &&
    $past(ctl_op_i) inside {PSF_OP_JUMP, PSF_OP_CALL, PSF_OP_RET} |->
    dummy_o && !instr_valid_o && rom_addr_o[12:0] == $past(ctl_target_i))
    else $error("transfer without target or dummy");
  skip_a: assert property (cycle_last_o && $past(instr_valid_o) &&
    $past(ctl_op_i) == PSF_OP_SKIP |-> dummy_o == $past(skip_true_i))
    else $error("skip dummy does not follow condition");
  irq_vec_a: assert property (cycle_last_o && $past(instr_valid_o) &&
    $past(ctl_op_i) == PSF_OP_NONE && $past(irq_t0_i || irq_t1_i) |-> dummy_o &&
    rom_addr_o[12:0] == ($past(irq_t0_i) ? 13'h0008 : 13'h000C))
    else $error("interrupt vector wrong");
  dummy_quiet_a: assert property (cycle_last_o && $past(dummy_o) |->
    !dummy_o && instr_valid_o)
    else $error("dummy slot acted on a request");
  reset_a: assert property ($fell(srst_i) |->
    (rom_addr_o == 17'h00000 && !instr_valid_o) [*7])
    else $error("fetch not at word zero after reset");
  bus_ans_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o)
    else $error("register access not answered next cycle");
  phase_last_a: assert property (cycle_last_o |-> phase_o == 2'h3)
    else $error("cycle end not in the last phase");
  low_jump_a: assert property (cycle_last_o && $past(instr_valid_o) &&
    $past(ctl_op_i) == PSF_OP_IPLO |-> dummy_o &&
    rom_addr_o[12:8] == $past(rom_addr_o[12:8]) &&
    rom_addr_o[7:0] == $past(ctl_target_i[7:0]))
    else $error("low byte jump left the page");
endmodule

bind psf_sequencer psf_sva u_sva (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .rom_addr_o(rom_addr_o), .instr_addr_o(instr_addr_o), .instr_valid_o(instr_valid_o),
  .dummy_o(dummy_o), .cycle_last_o(cycle_last_o), .phase_o(phase_o),
  .ctl_op_i(ctl_op_i), .ctl_target_i(ctl_target_i), .skip_true_i(skip_true_i),
  .irq_t0_i(irq_t0_i), .irq_t1_i(irq_t1_i));

// ===== bench/psf_rom_model.sv
`timescale 1ns/1ps
module psf_rom_model (
  input  wire logic        ref_clk_i,
  input  wire logic [16:0] rom_addr_i,
  input  wire logic        rom_rd_i,
  output logic      [15:0] rom_data_o
);
  // ********
  // Word store
  // ********
  // Words scramble the address so each fetch is traceable; idle output
  // toggles so a stale word can never pass for a fresh one
  initial rom_data_o = 16'h0000;
  always @(posedge ref_clk_i) begin
    if (rom_rd_i) begin
      rom_data_o <= rom_addr_i[15:0] ^ 16'hA5C3;
    end else begin
      rom_data_o <= ~rom_data_o;
    end
  end
endmodule

// ===== bench/psf_sequencer_test.sv
`timescale 1ns/1ps
module psf_sequencer_test import psf_pkg::*;;
  logic        ref_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [2:0]  ctl_op_i = 3'h0;
  logic [12:0] ctl_target_i = 13'h0;
  logic        skip_true_i = 1'b0;
  logic        irq_t0_i = 1'b0;
  logic        irq_t1_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [16:0] rom_addr_o;
  logic        rom_rd_o;
  logic [15:0] rom_data_i;
  logic [15:0] instr_o;
  logic        instr_valid_o;
  logic [12:0] instr_addr_o;
  logic [12:0] link_addr_o;
  logic        dummy_o;
  logic        cycle_last_o;
  logic [1:0]  phase_o;
  logic        irq_ack_o;
  logic        push_o;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  psf_sequencer dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
    .rom_data_i(rom_data_i), .instr_o(instr_o), .instr_valid_o(instr_valid_o),
    .instr_addr_o(instr_addr_o), .dummy_o(dummy_o), .cycle_last_o(cycle_last_o),
    .phase_o(phase_o), .ctl_op_i(ctl_op_i), .ctl_target_i(ctl_target_i),
    .skip_true_i(skip_true_i), .irq_t0_i(irq_t0_i), .irq_t1_i(irq_t1_i),
    .irq_ack_o(irq_ack_o), .push_o(push_o), .link_addr_o(link_addr_o));
  psf_rom_model u_rom (.ref_clk_i(ref_clk_i), .rom_addr_i(rom_addr_o), .rom_rd_i(rom_rd_o),
                       .rom_data_o(rom_data_i));

  // ********
  // Helpers
  // ********
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Global ceiling: run needs a few hundred cycles, so a hang ends quickly
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end

  // One register access, held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // Returns at the sample where a fresh instruction slot is shown
  task wait_e;
    do @(posedge ref_clk_i); while (cycle_last_o !== 1'b1);
  endtask

  // Offer one request to an executing slot and check the next fetch
  task xfer(input logic [2:0] op, input logic [12:0] tgt, input logic sk, input logic i0,
            input logic i1, input logic [12:0] pc, input logic dm);
    logic irq_e;
    // An interrupt is taken only when the slot itself does not transfer
    irq_e = (op == PSF_OP_NONE || (op == PSF_OP_SKIP && !sk)) && (i0 || i1);
    while (instr_valid_o !== 1'b1) wait_e;
    ctl_op_i <= op;
    ctl_target_i <= tgt;
    skip_true_i <= sk;
    irq_t0_i <= i0;
    irq_t1_i <= i1;
    wait_e;
    {ctl_op_i, skip_true_i, irq_t0_i, irq_t1_i} <= 6'h00;
    check(rom_addr_o[12:0], pc);
    check(dummy_o, dm);
    check(instr_o, {3'h0, instr_addr_o} ^ 16'hA5C3);
    check(instr_valid_o, !dm);
    check(push_o, irq_e || op == PSF_OP_CALL);
    check(irq_ack_o, irq_e);
    // Let an edge pass so the next call never drives in this time step
    @(posedge ref_clk_i);
  endtask

  // ********
  // Scenarios
  // ********
  initial begin
    repeat (20) @(posedge ref_clk_i);
    check(rom_rd_o, 1'b0);
    srst_i <= 1'b0;
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    check(rom_addr_o, 32'h0);
    check(rom_rd_o, 1'b1);
    wait_e;
    xfer(PSF_OP_NONE, 13'h0, 1'b0, 1'b0, 1'b0, 13'h0002, 1'b0);
    xfer(PSF_OP_JUMP, 13'h1FFE, 1'b0, 1'b0, 1'b0, 13'h1FFE, 1'b1);
    wait_e;
    xfer(PSF_OP_NONE, 13'h0, 1'b0, 1'b0, 1'b0, 13'h0000, 1'b0);
    check(rom_addr_o[16:13], 4'h0);
    wait_e;
    xfer(PSF_OP_CALL, 13'h0123, 1'b0, 1'b0, 1'b0, 13'h0123, 1'b1);
    check(link_addr_o, 13'h0001);
    xfer(PSF_OP_RET, 13'h0456, 1'b0, 1'b0, 1'b0, 13'h0456, 1'b1);
    xfer(PSF_OP_SKIP, 13'h0, 1'b0, 1'b0, 1'b0, 13'h0458, 1'b0);
    xfer(PSF_OP_SKIP, 13'h0, 1'b1, 1'b0, 1'b0, 13'h0459, 1'b1);
    xfer(PSF_OP_NONE, 13'h0, 1'b0, 1'b1, 1'b0, 13'h0008, 1'b1);
    xfer(PSF_OP_NONE, 13'h0, 1'b0, 1'b0, 1'b1, 13'h000C, 1'b1);
    xfer(PSF_OP_NONE, 13'h0, 1'b0, 1'b1, 1'b1, 13'h0008, 1'b1);
    xfer(PSF_OP_JUMP, 13'h0100, 1'b0, 1'b1, 1'b0, 13'h0100, 1'b1);
    wait_e;
    // Short jump keeps the page of the word under fetch
    bus(1'b1, 8'h18, 32'h5A);
    wait_e;
    check(rom_addr_o[12:0], 13'h015A);
    check(dummy_o, 1'b1);
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h5A);
    // A request during the dummy slot must be ignored
    ctl_op_i <= PSF_OP_JUMP;
    ctl_target_i <= 13'h0777;
    wait_e;
    ctl_op_i <= PSF_OP_NONE;
    check(rom_addr_o[12:0], 13'h015B);
    check(dummy_o, 1'b0);
    // Write with the low lane disabled is dropped
    avs_byteenable_i <= 4'hE;
    bus(1'b1, 8'h18, 32'h33);
    avs_byteenable_i <= 4'hF;
    wait_e;
    check(dummy_o, 1'b0);
    // Bank change lands only at the second slot start after the write
    bus(1'b1, 8'h40, 32'h9);
    wait_e;
    check(rom_addr_o[16:13], 4'h0);
    wait_e;
    check(rom_addr_o, {4'h9, 13'h015E});
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h9);
    bus(1'b1, 8'h7C, 32'hFF);
    bus(1'b0, 8'h7C, 32'h0);
    check(rd, 32'h0);
    // Second reset in mid-run clears counter and bank
    srst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    wait_e;
    wait_e;
    check(rom_addr_o, 32'h2);
    // Executed low byte write keeps the page; only eight bits change
    xfer(PSF_OP_JUMP, 13'h0A10, 1'b0, 1'b0, 1'b0, 13'h0A10, 1'b1);
    xfer(PSF_OP_IPLO, 13'h1F33, 1'b0, 1'b0, 1'b0, 13'h0A33, 1'b1);
    // Status shows the bank delay stage, then the pending low byte write
    bus(1'b1, 8'h40, 32'h3);
    bus(1'b0, 8'h44, 32'h0);
    check(rd, 32'h00200A33);
    bus(1'b1, 8'h18, 32'h44);
    bus(1'b0, 8'h44, 32'h0);
    check(rd, 32'h00500A34);
    wait_e;
    check(rom_addr_o, {4'h3, 13'h0A44});
    summarize();
  end
endmodule
